/* hw/pfc_pkg.sv */
package pfc_pkg;
	// fault flag carrier, bit weight = code weight
	typedef struct packed {
		logic tpulse;
		logic sync;
		logic optic;
		logic fuse;
	} pfc_flt_t;

	// configuration pin carrier
	typedef struct packed {
		logic pol;
		logic pitch_hi;
		logic pitch_lo;
		logic size;
	} pfc_cfg_t;

	typedef enum logic [1:0] {
		PITCH_PROP,
		PITCH_10,
		PITCH_12,
		PITCH_15
	} pfc_pitch_t;

	typedef enum logic {
		DT_IDLE,
		DT_RUN
	} pfc_dt_t;

	// register byte offsets
	localparam logic [7:0] A_STAT  = 8'h00;
	localparam logic [7:0] A_ISTAT = 8'h04;
	localparam logic [7:0] A_IMASK = 8'h08;
	localparam logic [7:0] A_CTRL  = 8'h0C;

	// interrupt event bits
	localparam int EV_FLT_ON  = 0;
	localparam int EV_FLT_OFF = 1;
	localparam int EV_CHR     = 2;
	localparam int EV_DOT     = 3;
	localparam int EV_N       = 4;

	localparam int         ST_PAD   = 21;
	localparam int         CTRL_PAD = 31;
	localparam logic       CTRL_RST = 1'h1;
	localparam logic [7:0] FONT_BASIC = 8'h60;
	localparam logic [7:0] FONT_EXT   = 8'h80;
	localparam logic [3:0] CODE_LIMIT = 4'hC;

	// timing
	localparam int CLK_MHZ     = 40;
	localparam int BEAM_TO_US  = 100;
	localparam int BEAM_CYC    = BEAM_TO_US * CLK_MHZ;
	localparam int FLASH_MS    = 250;
	localparam int FLASH_CYC   = FLASH_MS * CLK_MHZ * 1000;
endpackage : pfc_pkg

/* hw/pfc_top.sv */
`timescale 1ns/100ps
// Summary of operation
// [RULE_01] any engine fault flashes service lamp and holds busy, refusing print work
// [RULE_02] display code is OR of weights 1,2,4,8; codes C-F never shown
// [RULE_03] optical flag on missing beam detect or failed detect path
// [RULE_04] sync flag when no sync mark seen during warm-up
// [RULE_05] offline printer test press starts repeated dot test; next press stops
// [RULE_06] online controller test press prints exactly one character page
// [RULE_07] terminal-ready output polarity chosen by a select pin
// [RULE_08] two pitch bits choose tenth, twelfth, fifteenth inch or proportional
// [RULE_09] size bit on gives 96-char set, off gives 128-char set
// [RULE_10] code follows flag changes; busy drops only when all flags clear
module pfc_top #(
	parameter int FLASH_CYC = pfc_pkg::FLASH_CYC,
	parameter int BEAM_CYC  = pfc_pkg::BEAM_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// engine sensors
	input  wire logic        fuse_fault,
	input  wire logic        beam_detect,
	input  wire logic        beam_path_fail,
	input  wire logic        warmup,
	input  wire logic        sync_mark,
	input  wire logic        tpulse_fault,
	// operator and print work
	input  wire logic        online,
	input  wire logic        printer_test_btn,
	input  wire logic        ctrl_test_btn,
	input  wire logic        print_req,
	// configuration
	input  wire logic        terminal_ready_polarity_select,
	input  wire logic        font_pitch_select_low,
	input  wire logic        font_pitch_select_high,
	input  wire logic        font_size_select,
	input  wire logic        host_ready,
	// status outputs
	output logic             service_led,
	output logic             busy,
	output logic      [3:0]  fault_code,
	output logic             print_accept,
	output logic             dot_test_active,
	output logic             char_page_start,
	output logic             terminal_ready,
	output pfc_pkg::pfc_pitch_t font_pitch,
	output logic      [7:0]  font_chars,
	output logic             irq
);

	localparam int BW = $clog2(BEAM_CYC + 1);
	localparam int FW = $clog2(FLASH_CYC + 1);

	function automatic logic [3:0] code_of(input pfc_pkg::pfc_flt_t f);
		// timing pulse hides sync so C-F cannot occur
		code_of = {f.tpulse, f.sync & ~f.tpulse, f.optic, f.fuse};
	endfunction : code_of

	function automatic pfc_pkg::pfc_pitch_t pitch_of(input pfc_pkg::pfc_cfg_t c);
		unique case ({c.pitch_lo, c.pitch_hi})
			2'h3: pitch_of = pfc_pkg::PITCH_10;
			2'h1: pitch_of = pfc_pkg::PITCH_12;
			2'h2: pitch_of = pfc_pkg::PITCH_15;
			2'h0: pitch_of = pfc_pkg::PITCH_PROP;
		endcase
	endfunction : pitch_of

	pfc_pkg::pfc_flt_t       flt;
	pfc_pkg::pfc_cfg_t       cfg;
	pfc_pkg::pfc_dt_t        dt_state;
	logic [BW-1:0]           beam_cnt;
	logic [FW-1:0]           flash_cnt;
	logic                    beam_lost;
	logic                    warm_d;
	logic                    sync_seen;
	logic                    ptb_d;
	logic                    ctb_d;
	logic                    ptb_rise;
	logic                    ctb_rise;
	logic                    any_f;
	logic                    beam_chk_en;
	logic [pfc_pkg::EV_N-1:0] istat;
	logic [pfc_pkg::EV_N-1:0] imask;
	logic [pfc_pkg::EV_N-1:0] ev;
	logic [pfc_pkg::EV_N-1:0] iclr;
	logic [pfc_pkg::EV_N-1:0] next_istat;
	logic                    setup;
	logic                    acc_wr;
	logic                    hit;
	logic [31:0]             rd_mux;

	assign cfg = '{pol: terminal_ready_polarity_select,
		pitch_hi: font_pitch_select_high,
		pitch_lo: font_pitch_select_low,
		size: font_size_select};
	assign ptb_rise  = printer_test_btn & ~ptb_d;
	assign ctb_rise  = ctrl_test_btn & ~ctb_d;
	assign any_f     = |flt;
	assign beam_lost = beam_cnt == BW'(BEAM_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// fault sensing

	// beam watchdog, restarted by each detect pulse
	always_ff @(posedge clk)
	begin
		if (rst || beam_detect || !beam_chk_en)
			beam_cnt <= '0;
		else if (!beam_lost)
			beam_cnt <= beam_cnt + BW'(1);
	end

	// warm-up window tracking
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			warm_d    <= 1'b0;
			sync_seen <= 1'b0;
		end
		else
		begin
			warm_d <= warmup;
			if (warmup && !warm_d)
				sync_seen <= sync_mark;
			else if (warmup && sync_mark)
				sync_seen <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			flt <= '0;
		else
		begin
			flt.fuse   <= fuse_fault;
			flt.optic  <= beam_lost | beam_path_fail; // see [RULE_03]
			flt.tpulse <= tpulse_fault;
			if (warmup && !warm_d)
				flt.sync <= 1'b0;
			else if (!warmup && warm_d)
				flt.sync <= ~sync_seen & ~sync_mark; // see [RULE_04]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// display, busy and lamp

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fault_code <= '0;
			busy       <= 1'b0;
		end
		else
		begin
			fault_code <= code_of(flt); // see [RULE_02] see [RULE_10]
			busy       <= any_f; // see [RULE_01] see [RULE_10]
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || !busy)
		begin
			flash_cnt   <= '0;
			service_led <= 1'b0;
		end
		else if (flash_cnt == FW'(FLASH_CYC - 1))
		begin
			flash_cnt   <= '0;
			service_led <= ~service_led; // see [RULE_01]
		end
		else
			flash_cnt <= flash_cnt + FW'(1);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			print_accept <= 1'b0;
		else
			print_accept <= print_req & ~busy & ~any_f; // see [RULE_01]
	end

	////////////////////////////////////////////////////////////////////////////
	// self tests

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ptb_d <= 1'b0;
			ctb_d <= 1'b0;
		end
		else
		begin
			ptb_d <= printer_test_btn;
			ctb_d <= ctrl_test_btn;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dt_state        <= pfc_pkg::DT_IDLE;
			dot_test_active <= 1'b0;
		end
		else
		begin
			unique case (dt_state)
				pfc_pkg::DT_IDLE:
					if (ptb_rise && !online)
					begin
						dt_state        <= pfc_pkg::DT_RUN; // see [RULE_05]
						dot_test_active <= 1'b1;
					end
				pfc_pkg::DT_RUN:
					if (ptb_rise)
					begin
						dt_state        <= pfc_pkg::DT_IDLE; // see [RULE_05]
						dot_test_active <= 1'b0;
					end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			char_page_start <= 1'b0;
		else
			char_page_start <= ctb_rise & online; // see [RULE_06]
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration pins

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			terminal_ready <= 1'b0;
			font_pitch     <= pfc_pkg::PITCH_PROP;
			font_chars     <= pfc_pkg::FONT_EXT;
		end
		else
		begin
			terminal_ready <= cfg.pol ? host_ready : ~host_ready; // see [RULE_07]
			font_pitch     <= pitch_of(cfg); // see [RULE_08]
			font_chars     <= cfg.size ? pfc_pkg::FONT_BASIC
				: pfc_pkg::FONT_EXT; // see [RULE_09]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts

	always_comb
	begin
		ev = '0;
		ev[pfc_pkg::EV_FLT_ON]  = any_f & ~busy;
		ev[pfc_pkg::EV_FLT_OFF] = ~any_f & busy;
		ev[pfc_pkg::EV_CHR]     = ctb_rise & online;
		ev[pfc_pkg::EV_DOT]     = ptb_rise & (~online | dot_test_active);
		iclr = '0;
		if (acc_wr && paddr == pfc_pkg::A_ISTAT)
			iclr = pwdata[pfc_pkg::EV_N-1:0];
		// a new event wins over its clear
		next_istat = (istat & ~iclr) | ev;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			istat <= '0;
			irq   <= 1'b0;
		end
		else
		begin
			istat <= next_istat;
			irq   <= |(next_istat & imask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb slave, one wait-free access phase

	assign setup  = psel & ~penable;
	assign acc_wr = psel & penable & pready & pwrite;
	assign hit    = paddr == pfc_pkg::A_STAT || paddr == pfc_pkg::A_ISTAT
		|| paddr == pfc_pkg::A_IMASK || paddr == pfc_pkg::A_CTRL;

	always_comb
	begin
		rd_mux = '0;
		unique case (paddr)
			pfc_pkg::A_STAT:
				rd_mux = {pfc_pkg::ST_PAD'(0), service_led, dot_test_active,
					busy, flt, fault_code};
			pfc_pkg::A_ISTAT:
				rd_mux = {(32 - pfc_pkg::EV_N)'(0), istat};
			pfc_pkg::A_IMASK:
				rd_mux = {(32 - pfc_pkg::EV_N)'(0), imask};
			pfc_pkg::A_CTRL:
				rd_mux = {pfc_pkg::CTRL_PAD'(0), beam_chk_en};
			default:
				rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~hit;
			if (setup && !pwrite)
				prdata <= rd_mux;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			imask       <= '0;
			beam_chk_en <= pfc_pkg::CTRL_RST;
		end
		else if (acc_wr)
		begin
			if (paddr == pfc_pkg::A_IMASK)
				imask <= pwdata[pfc_pkg::EV_N-1:0];
			if (paddr == pfc_pkg::A_CTRL)
				beam_chk_en <= pwdata[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_busy_on;
		any_f |=> busy ##1 (print_accept == 1'b0);
	endproperty
	a_busy_on: assert property (p_busy_on) else $error("busy not raised"); // see [RULE_01]

	property p_led_off;
		!busy |=> !service_led;
	endproperty
	a_led_off: assert property (p_led_off) else $error("lamp lit while idle"); // see [RULE_01]

	property p_code;
		1'b1 |=> fault_code == code_of($past(flt));
	endproperty
	a_code: assert property (p_code) else $error("fault code wrong"); // see [RULE_02]

	property p_no_cf;
		fault_code < pfc_pkg::CODE_LIMIT;
	endproperty
	a_no_cf: assert property (p_no_cf) else $error("undefined code shown"); // see [RULE_02]

	property p_optic;
		beam_path_fail |=> flt.optic ##1 fault_code[1];
	endproperty
	a_optic: assert property (p_optic) else $error("optical fault missed"); // see [RULE_03]

	property p_sync;
		$fell(warmup) && !sync_seen && !sync_mark |=> flt.sync;
	endproperty
	a_sync: assert property (p_sync) else $error("sync fault missed"); // see [RULE_04]

	property p_dot;
		ptb_rise && !online && !dot_test_active |=> dot_test_active;
	endproperty
	a_dot: assert property (p_dot) else $error("dot test not started"); // see [RULE_05]

	property p_dot_stop;
		ptb_rise && dot_test_active |=> !dot_test_active;
	endproperty
	a_dot_stop: assert property (p_dot_stop) else $error("dot test not stopped"); // see [RULE_05]

	property p_chr;
		ctb_rise && online |=> char_page_start ##1 !char_page_start;
	endproperty
	a_chr: assert property (p_chr) else $error("char page not single"); // see [RULE_06]

	property p_dtr;
		1'b1 |=> terminal_ready == ($past(cfg.pol) ~^ $past(host_ready));
	endproperty
	a_dtr: assert property (p_dtr) else $error("ready polarity wrong"); // see [RULE_07]

	property p_pitch;
		font_pitch_select_low && font_pitch_select_high |=> font_pitch == pfc_pkg::PITCH_10;
	endproperty
	a_pitch: assert property (p_pitch) else $error("pitch wrong"); // see [RULE_08]

	property p_size;
		!font_size_select |=> font_chars == pfc_pkg::FONT_EXT;
	endproperty
	a_size: assert property (p_size) else $error("font size wrong"); // see [RULE_09]

	property p_release;
		busy && !any_f |=> !busy;
	endproperty
	a_release: assert property (p_release) else $error("busy held"); // see [RULE_10]

	c_fault: cover property (any_f ##1 busy ##[1:20] !busy);
	c_dot: cover property (dot_test_active ##[1:50] !dot_test_active);
	c_chr: cover property (char_page_start);
	c_irq: cover property ($rose(irq));

endmodule : pfc_top

/* sim/pfc_eng_model.sv */
`timescale 1ns/100ps
module pfc_eng_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// bench commands
	input  wire logic beam_on,
	input  wire logic sync_ok,
	input  wire logic warm_cmd,
	// sensor lines
	output logic      beam_detect,
	output logic      warmup,
	output logic      sync_mark
);
	logic [1:0] ph;

	always_ff @(posedge clk)
	begin
		if (rst)
			ph <= 2'h0;
		else
			ph <= ph + 2'h1;
	end

	// beam seen every fourth cycle while the laser runs
	always_ff @(posedge clk)
	begin
		beam_detect <= beam_on && (ph == 2'h3) && !rst;
		warmup      <= warm_cmd && !rst;
		sync_mark   <= sync_ok && warm_cmd && (ph == 2'h1) && !rst;
	end
endmodule : pfc_eng_model

/* sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        fuse_fault, beam_detect, beam_path_fail, warmup, sync_mark;
	logic        tpulse_fault, online, p_btn, c_btn, print_req, host_ready;
	logic        pol, p_lo, p_hi, f_size, beam_on, sync_ok, warm_cmd;
	logic        service_led, busy, print_accept, dot_on, page, t_rdy, irq;
	logic [3:0]  fault_code;
	logic [7:0]  font_chars;
	logic [3:0]  v;
	pfc_pkg::pfc_pitch_t font_pitch;
	int          error_cnt, total_checks, n;

	always #12.5 clk = ~clk;

	pfc_eng_model ENG (.clk(clk), .rst(rst), .beam_on(beam_on), .sync_ok(sync_ok),
		.warm_cmd(warm_cmd), .beam_detect(beam_detect), .warmup(warmup),
		.sync_mark(sync_mark));

	pfc_top #(.FLASH_CYC(4), .BEAM_CYC(8)) DUT (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fuse_fault(fuse_fault),
		.beam_detect(beam_detect), .beam_path_fail(beam_path_fail), .warmup(warmup),
		.sync_mark(sync_mark), .tpulse_fault(tpulse_fault), .online(online),
		.printer_test_btn(p_btn), .ctrl_test_btn(c_btn), .print_req(print_req),
		.terminal_ready_polarity_select(pol), .font_pitch_select_low(p_lo),
		.font_pitch_select_high(p_hi), .font_size_select(f_size),
		.host_ready(host_ready), .service_led(service_led), .busy(busy),
		.fault_code(fault_code), .print_accept(print_accept),
		.dot_test_active(dot_on), .char_page_start(page), .terminal_ready(t_rdy),
		.font_pitch(font_pitch), .font_chars(font_chars), .irq(irq));

	task automatic results();
		$display("errors %0d checks %0d", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask : tick

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic press(input logic c);
		n = 0;
		@(posedge clk);
		if (c)
			c_btn <= 1'b1;
		else
			p_btn <= 1'b1;
		repeat (6)
		begin
			@(posedge clk);
			n += (page === 1'b1);
		end
		c_btn <= 1'b0;
		p_btn <= 1'b0;
		tick(3);
	endtask : press

	function automatic logic [3:0] ecode(input logic t, s, o, f);
		return {t, s & ~t, o, f};
	endfunction : ecode

	function automatic logic [1:0] epitch(input logic lo, hi);
		return (lo && hi) ? 2'h1 : (hi ? 2'h2 : (lo ? 2'h3 : 2'h0));
	endfunction : epitch

	initial
	begin
		#200000;
		error_cnt++;
		results();
	end

	initial
	begin
		{clk, psel, penable, pwrite, paddr, pwdata, fuse_fault, beam_path_fail} = '0;
		{tpulse_fault, online, p_btn, c_btn, print_req, host_ready} = '0;
		{pol, p_lo, p_hi, f_size, sync_ok, warm_cmd} = '0;
		beam_on = 1'b1;
		rst = 1'b1;
		error_cnt = 0;
		total_checks = 0;
		void'($urandom(72468));
		tick(10);
		rst <= 1'b0;
		tick(2);
		chk("chars", font_chars, 32'h80);
		chk("pitch", font_pitch, 32'h0);
		apb(1'b0, pfc_pkg::A_CTRL, 32'h0);
		chk("ctrl", rd, 32'h1);
		for (int i = 0; i < 16; i++)
		begin
			{pol, p_hi, p_lo, f_size} <= i[3:0];
			host_ready <= $urandom;
			tick(3);
			chk("tready", t_rdy, 1'(pol ? host_ready : ~host_ready));
			chk("pitch", font_pitch, epitch(p_lo, p_hi));
			chk("chars", font_chars, f_size ? 32'h60 : 32'h80);
		end
		for (int i = 0; i < 24; i++)
		begin
			v = $urandom;
			{tpulse_fault, beam_path_fail, fuse_fault, print_req} <= v;
			tick(4);
			chk("code", fault_code, ecode(v[3], 1'b0, v[2], v[1]));
			chk("busy", busy, |v[3:1]);
			chk("accept", print_accept, v[0] & ~|v[3:1]);
		end
		{tpulse_fault, beam_path_fail, fuse_fault, print_req} <= 4'h0;
		apb(1'b1, pfc_pkg::A_IMASK, 32'h1);
		apb(1'b1, pfc_pkg::A_ISTAT, 32'hF);
		tick(3);
		chk("irq", irq, 1'b0);
		fuse_fault <= 1'b1;
		tick(8);
		chk("irq", irq, 1'b1);
		apb(1'b0, pfc_pkg::A_STAT, 32'h0);
		chk("stat", rd[8:0], 32'h111);
		n = 0;
		repeat (16)
		begin
			@(posedge clk);
			n += (service_led === 1'b1);
		end
		chk("led", n, 8);
		apb(1'b1, pfc_pkg::A_IMASK, 32'h0);
		tick(3);
		chk("irq", irq, 1'b0);
		apb(1'b1, pfc_pkg::A_IMASK, 32'h1);
		fuse_fault <= 1'b0;
		tick(4);
		chk("busy", busy, 1'b0);
		chk("led", service_led, 1'b0);
		apb(1'b1, pfc_pkg::A_ISTAT, 32'h1);
		tick(3);
		chk("irq", irq, 1'b0);
		apb(1'b0, pfc_pkg::A_ISTAT, 32'h0);
		chk("istat", rd, 32'h2);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", err, 1'b1);
		chk("unmapped", rd, 32'h0);
		beam_on <= 1'b0;
		tick(14);
		chk("code", fault_code, 32'h2);
		// watchdog disabled: missing beam no longer a fault
		apb(1'b1, pfc_pkg::A_CTRL, 32'h0);
		tick(4);
		chk("code", fault_code, 32'h0);
		apb(1'b1, pfc_pkg::A_CTRL, 32'h1);
		beam_on <= 1'b1;
		tick(8);
		chk("code", fault_code, 32'h0);
		warm_cmd <= 1'b1;
		tick(10);
		warm_cmd <= 1'b0;
		tick(5);
		chk("code", fault_code, 32'h4);
		tpulse_fault <= 1'b1;
		tick(4);
		chk("code", fault_code, 32'h8);
		tpulse_fault <= 1'b0;
		{warm_cmd, sync_ok} <= 2'h3;
		tick(10);
		warm_cmd <= 1'b0;
		tick(5);
		chk("code", fault_code, 32'h0);
		online <= 1'b0;
		press(1'b0);
		chk("dot", dot_on, 1'b1);
		press(1'b0);
		chk("dot", dot_on, 1'b0);
		online <= 1'b1;
		press(1'b0);
		chk("dot", dot_on, 1'b0);
		press(1'b1);
		chk("pages", n, 1);
		press(1'b1);
		chk("pages", n, 1);
		online <= 1'b0;
		press(1'b1);
		chk("pages", n, 0);
		apb(1'b0, pfc_pkg::A_ISTAT, 32'h0);
		chk("istat", rd[3:2], 32'h3);
		results();
	end
endmodule : tb_top
